// >>> hw/cpst_regs.svh
`ifndef CPST_REGS_SVH
`define CPST_REGS_SVH

// ----------------------------------------------------------------
// widths of the parallel port
// ----------------------------------------------------------------
`define CPST_ADDR_W        8
`define CPST_DATA_W        16
`define CPST_BYTE_W        8
`define CPST_MEM_DEPTH     256
`define CPST_STREAMS       16

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CPST_CLK_PERIOD_NS 20
`define CPST_RESET_MIN_NS  100
`define CPST_RESET_MIN_CYC \
    ((`CPST_RESET_MIN_NS + `CPST_CLK_PERIOD_NS - 1) / `CPST_CLK_PERIOD_NS)
`define CPST_RESET_CNT_W   4

// ----------------------------------------------------------------
// reset and idle values
// ----------------------------------------------------------------
`define CPST_PULL_BYTE     8'hFF
`define CPST_DATA_RESET    16'h0000
`define CPST_ADDR_RESET    8'h00
`define CPST_OE_OFF_ALL    16'hFFFF

`endif

// >>> hw/cpst_pkg.sv
package cpst_pkg;

    // how the port strobes are read
    typedef enum logic [2:0] {
        CPST_STYLE_DS_PLAIN = 3'h1,
        CPST_STYLE_DS_MUXED = 3'h2,
        CPST_STYLE_RW_STROBE = 3'h4
    } cpst_style_e;

    typedef enum logic [2:0] {
        CPST_D_IDLE = 3'h1,
        CPST_D_ACK  = 3'h2,
        CPST_D_HIGH = 3'h4
    } cpst_dev_state_e;

    typedef enum logic [5:0] {
        CPST_H_IDLE   = 6'h01,
        CPST_H_ADDR   = 6'h02,
        CPST_H_LATCH  = 6'h04,
        CPST_H_STROBE = 6'h08,
        CPST_H_END    = 6'h10,
        CPST_H_RST    = 6'h20
    } cpst_host_state_e;

endpackage

// >>> hw/cpst_if.sv
`timescale 1ns/10ps
`include "cpst_regs.svh"

interface cpst_if;
    logic                     port_sel_n;
    logic                     data_strobe;
    logic                     dir_write_sel;
    logic                     addr_latch_strobe;
    logic                     bus_style_select;
    logic [`CPST_ADDR_W-1:0]  addr_lines;
    logic                     dev_reset_n;
    logic [`CPST_BYTE_W-1:0]  host_low_out;
    logic                     host_low_oe_n;
    logic [`CPST_BYTE_W-1:0]  host_high_out;
    logic                     host_high_oe_n;
    logic [`CPST_BYTE_W-1:0]  dev_low_out;
    logic                     dev_low_oe_n;
    logic [`CPST_BYTE_W-1:0]  dev_high_out;
    logic                     dev_high_oe_n;
    logic                     ack_out;
    logic                     ack_oe_n;
    logic [`CPST_BYTE_W-1:0]  muxed_low_byte_lines;
    logic [`CPST_BYTE_W-1:0]  data_high_byte;
    logic                     transfer_ack_n;

    // ----------------------------------------------------------------
    // wire resolution, released lines are pulled high
    // ----------------------------------------------------------------
    assign muxed_low_byte_lines = !dev_low_oe_n  ? dev_low_out  :
                                  !host_low_oe_n ? host_low_out :
                                  `CPST_PULL_BYTE;
    assign data_high_byte       = !dev_high_oe_n  ? dev_high_out  :
                                  !host_high_oe_n ? host_high_out :
                                  `CPST_PULL_BYTE;
    assign transfer_ack_n       = !ack_oe_n ? ack_out : 1'b1;

    modport dev (
        input  port_sel_n, data_strobe, dir_write_sel, addr_latch_strobe,
        input  bus_style_select, addr_lines, dev_reset_n,
        input  muxed_low_byte_lines, data_high_byte,
        output dev_low_out, dev_low_oe_n, dev_high_out, dev_high_oe_n,
        output ack_out, ack_oe_n
    );

    modport host (
        output port_sel_n, data_strobe, dir_write_sel, addr_latch_strobe,
        output bus_style_select, addr_lines, dev_reset_n,
        output host_low_out, host_low_oe_n, host_high_out, host_high_oe_n,
        input  muxed_low_byte_lines, data_high_byte, transfer_ack_n
    );
endinterface

// >>> hw/cpst_dev.sv
`timescale 1ns/10ps
`include "cpst_regs.svh"

// What this block does
// - accesses honoured only while port select low
// - plain mode: address from dedicated address lines
// - muxed data-strobe style: strobe active high
// - plain data-strobe style: strobe active low
// - read strobe low turns data lines to outputs
// - direction select picks read or write
// - write strobe low samples data lines
// - latch strobe used only in muxed mode
// - host grounds latch strobe in plain mode
// - device reset clears state, floats all outputs
// - host holds device reset low 100 ns
// - style select high means muxed operation
// - muxed mode: low byte lines carry address
// - ack low on completion, high, then released
module cpst_dev
    import cpst_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    cpst_if.dev                            bus,
    input  wire logic [`CPST_STREAMS-1:0]  serial_data,
    output logic      [`CPST_STREAMS-1:0]  serial_out_streams,
    output logic      [`CPST_STREAMS-1:0]  serial_out_oe_n,
    input  wire logic [`CPST_ADDR_W-1:0]   core_rd_addr,
    output logic      [`CPST_DATA_W-1:0]   core_rd_data,
    output cpst_style_e                    active_style,
    output logic                           write_seen
);

    // ----------------------------------------------------------------
    // reset and mode
    // ----------------------------------------------------------------
    logic                      rst_int;
    logic                      muxed;
    logic                      ale_in;
    logic                      ale_q;
    logic                      ale_fall;
    logic [`CPST_ADDR_W-1:0]   addr_latch_q;
    cpst_style_e               muxed_style_q;
    cpst_style_e               style;
    logic [`CPST_ADDR_W-1:0]   acc_addr;
    logic                      acc_rd;
    logic                      acc_wr;
    logic                      acc_on;
    logic                      addr_ok_q;
    logic [`CPST_DATA_W-1:0]   wdata;
    logic [`CPST_DATA_W-1:0]   rd_data_q;
    logic [`CPST_DATA_W-1:0]   mem [`CPST_MEM_DEPTH];
    cpst_dev_state_e           state_q;
    cpst_dev_state_e           state_d;

    // pin reset and local reset act alike
    assign rst_int = reset | ~bus.dev_reset_n;
    assign muxed   = bus.bus_style_select;

    // ----------------------------------------------------------------
    // address latch
    // ----------------------------------------------------------------
    // latch strobe is masked outside muxed mode, so a floating or
    // toggling pin in plain mode cannot disturb the latch
    assign ale_in   = muxed & bus.addr_latch_strobe;
    assign ale_fall = ale_q & ~ale_in & ~bus.port_sel_n;

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            ale_q <= 1'b0;
        end else begin
            ale_q <= ale_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            addr_latch_q <= `CPST_ADDR_RESET;
        end else if (ale_fall) begin
            addr_latch_q <= bus.muxed_low_byte_lines;
        end
    end

    // the idle level of the strobe pin at the latch edge tells the
    // styles apart: a read strobe rests high, a data strobe rests low
    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            muxed_style_q <= CPST_STYLE_DS_MUXED;
        end else if (ale_fall) begin
            muxed_style_q <= bus.data_strobe ? CPST_STYLE_RW_STROBE
                                             : CPST_STYLE_DS_MUXED;
        end
    end

    // in muxed mode no strobe counts until this access has latched its
    // own address; the style taken from the previous access may be stale
    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            addr_ok_q <= 1'b0;
        end else if (ale_fall) begin
            addr_ok_q <= 1'b1;
        end else if (state_q == CPST_D_HIGH) begin
            addr_ok_q <= 1'b0;
        end
    end

    assign style        = muxed ? muxed_style_q : CPST_STYLE_DS_PLAIN;
    assign active_style = style;

    // held latch serves the whole access in muxed mode
    assign acc_addr = muxed ? addr_latch_q
                            : bus.addr_lines;

    // ----------------------------------------------------------------
    // strobe decode
    // ----------------------------------------------------------------
    always_comb begin
        acc_rd = 1'b0;
        acc_wr = 1'b0;
        case (style)
            CPST_STYLE_DS_MUXED: begin
                acc_rd = ~bus.port_sel_n & bus.data_strobe
                       & bus.dir_write_sel;
                acc_wr = ~bus.port_sel_n & bus.data_strobe
                       & ~bus.dir_write_sel;
            end
            CPST_STYLE_DS_PLAIN: begin
                acc_rd = ~bus.port_sel_n & ~bus.data_strobe
                       & bus.dir_write_sel;
                acc_wr = ~bus.port_sel_n & ~bus.data_strobe
                       & ~bus.dir_write_sel;
            end
            CPST_STYLE_RW_STROBE: begin
                acc_rd = ~bus.port_sel_n & ~bus.data_strobe;
                // write only while the read strobe is idle
                acc_wr = ~bus.port_sel_n & ~bus.dir_write_sel
                       & bus.data_strobe;
            end
            default: begin
                acc_rd = 1'b0;
                acc_wr = 1'b0;
            end
        endcase
        // address phase of a muxed access is never an access itself
        if (muxed && !addr_ok_q) begin
            acc_rd = 1'b0;
            acc_wr = 1'b0;
        end
    end

    // port select gates everything above
    assign acc_on = acc_rd | acc_wr;
    assign wdata  = {bus.data_high_byte, bus.muxed_low_byte_lines};

    // ----------------------------------------------------------------
    // access sequence
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            CPST_D_IDLE: begin
                if (acc_on) begin
                    state_d = CPST_D_ACK;
                end
            end
            CPST_D_ACK: begin
                if (!acc_on) begin
                    state_d = CPST_D_HIGH;
                end
            end
            CPST_D_HIGH: begin
                state_d = CPST_D_IDLE;
            end
            default: begin
                state_d = CPST_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            state_q <= CPST_D_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // memory is not cleared by reset; only its access state is
    always_ff @(posedge ref_clk) begin
        if (!rst_int && state_q == CPST_D_IDLE && acc_wr) begin
            mem[acc_addr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            rd_data_q <= `CPST_DATA_RESET;
        end else if (state_q == CPST_D_IDLE && acc_rd) begin
            rd_data_q <= mem[acc_addr];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            write_seen <= 1'b0;
        end else begin
            write_seen <= state_q == CPST_D_IDLE && acc_wr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            core_rd_data <= `CPST_DATA_RESET;
        end else begin
            core_rd_data <= mem[core_rd_addr];
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // data lines turn round as soon as a read strobe is decoded;
    // the acknowledge marks when the driven value is valid
    assign bus.dev_low_out   = rd_data_q[`CPST_BYTE_W-1:0];
    assign bus.dev_high_out  = rd_data_q[`CPST_DATA_W-1:`CPST_BYTE_W];
    assign bus.dev_low_oe_n  = ~(acc_rd & ~rst_int);
    assign bus.dev_high_oe_n = ~(acc_rd & ~rst_int);

    // driven high for one cycle before release, so a weak pull-up
    // only has to hold the level, not restore it
    assign bus.ack_out  = state_q == CPST_D_HIGH;
    assign bus.ack_oe_n = ~(state_q == CPST_D_ACK ||
                            state_q == CPST_D_HIGH);

    // ----------------------------------------------------------------
    // serial outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst_int) begin
            serial_out_streams <= `CPST_DATA_RESET;
            serial_out_oe_n    <= `CPST_OE_OFF_ALL;
        end else begin
            serial_out_streams <= serial_data;
            serial_out_oe_n    <= ~`CPST_OE_OFF_ALL;
        end
    end

endmodule

// >>> hw/cpst_host.sv
`timescale 1ns/10ps
`include "cpst_regs.svh"

module cpst_host
    import cpst_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset,
    cpst_if.host                          bus,
    input  wire logic                     muxed_mode,
    input  wire logic                     rw_strobes,
    input  wire logic                     req,
    input  wire logic                     req_write,
    input  wire logic [`CPST_ADDR_W-1:0]  req_addr,
    input  wire logic [`CPST_DATA_W-1:0]  req_wdata,
    input  wire logic                     rst_req,
    output logic                          busy,
    output logic                          done,
    output logic      [`CPST_DATA_W-1:0]  rdata
);

    cpst_host_state_e            state_q;
    logic                        mux_q;
    logic                        rws_q;
    logic                        wr_q;
    logic [`CPST_ADDR_W-1:0]     addr_q;
    logic [`CPST_DATA_W-1:0]     wdata_q;
    logic [`CPST_RESET_CNT_W-1:0] rcnt_q;
    logic                        strobe_on;
    logic                        addr_phase;

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    // coming out of reset the device reset pin is pulsed first
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= CPST_H_RST;
            rcnt_q  <= `CPST_RESET_CNT_W'(`CPST_RESET_MIN_CYC);
        end else begin
            case (state_q)
                CPST_H_IDLE: begin
                    if (rst_req) begin
                        state_q <= CPST_H_RST;
                        rcnt_q  <= `CPST_RESET_CNT_W'(`CPST_RESET_MIN_CYC);
                    end else if (req) begin
                        state_q <= muxed_mode ? CPST_H_ADDR : CPST_H_STROBE;
                    end
                end
                CPST_H_ADDR:   state_q <= CPST_H_LATCH;
                CPST_H_LATCH:  state_q <= CPST_H_STROBE;
                CPST_H_STROBE: begin
                    if (!bus.transfer_ack_n) begin
                        state_q <= CPST_H_END;
                    end
                end
                CPST_H_END:    state_q <= CPST_H_IDLE;
                CPST_H_RST: begin
                    // low for the full minimum before release
                    if (rcnt_q == `CPST_RESET_CNT_W'(1)) begin
                        state_q <= CPST_H_IDLE;
                    end
                    rcnt_q <= rcnt_q - `CPST_RESET_CNT_W'(1);
                end
                default:       state_q <= CPST_H_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mux_q   <= 1'b0;
            rws_q   <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= `CPST_ADDR_RESET;
            wdata_q <= `CPST_DATA_RESET;
        end else if (state_q == CPST_H_IDLE && req && !rst_req) begin
            mux_q   <= muxed_mode;
            rws_q   <= rw_strobes & muxed_mode;
            wr_q    <= req_write;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata <= `CPST_DATA_RESET;
        end else if (state_q == CPST_H_STROBE && !bus.transfer_ack_n
                     && !wr_q) begin
            rdata <= {bus.data_high_byte, bus.muxed_low_byte_lines};
        end
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    assign strobe_on  = state_q == CPST_H_STROBE;
    assign addr_phase = state_q == CPST_H_ADDR || state_q == CPST_H_LATCH;
    assign busy       = state_q != CPST_H_IDLE;
    assign done       = state_q == CPST_H_END;

    assign bus.dev_reset_n      = state_q != CPST_H_RST;
    assign bus.bus_style_select = mux_q;
    assign bus.port_sel_n       = ~(strobe_on | addr_phase);
    assign bus.addr_lines       = addr_q;
    // grounded in plain mode
    assign bus.addr_latch_strobe = mux_q & state_q == CPST_H_ADDR;

    // read strobe and write strobe, or data strobe and direction
    assign bus.data_strobe   = rws_q ? ~(strobe_on & ~wr_q) :
                               mux_q ? strobe_on : ~strobe_on;
    assign bus.dir_write_sel = rws_q ? ~(strobe_on & wr_q) : ~wr_q;

    assign bus.host_low_out   = addr_phase ? addr_q
                                           : wdata_q[`CPST_BYTE_W-1:0];
    assign bus.host_low_oe_n  = ~(addr_phase | (strobe_on & wr_q));
    assign bus.host_high_out  = wdata_q[`CPST_DATA_W-1:`CPST_BYTE_W];
    assign bus.host_high_oe_n = ~(strobe_on & wr_q);

endmodule

// >>> tb/cpst_port_props.sv
`timescale 1ns/10ps

module cpst_port_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic port_sel_n,
    input wire logic data_strobe,
    input wire logic dir_write_sel,
    input wire logic addr_latch_strobe,
    input wire logic bus_style_select,
    input wire logic dev_reset_n,
    input wire logic dev_low_oe_n,
    input wire logic dev_high_oe_n,
    input wire logic ack_out,
    input wire logic ack_oe_n,
    input wire logic transfer_ack_n
);
    // ----------------------------------------------------------------
    // port link properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_ack_low;  !ack_oe_n && !ack_out; endsequence
    sequence s_ack_high; !ack_oe_n && ack_out;  endsequence
    sequence s_plain_go;
        !bus_style_select && !port_sel_n && $fell(data_strobe);
    endsequence
    sequence s_mux_go;
        bus_style_select && !port_sel_n && $fell(addr_latch_strobe);
    endsequence

    property p_ack_sel;
        $fell(transfer_ack_n) |-> !$past(port_sel_n);
    endproperty
    // device reset also releases ack, so the sequence is cut short there
    property p_ack_end;
        disable iff (reset || !dev_reset_n)
        s_ack_low ##1 !(!ack_oe_n && !ack_out) |-> s_ack_high ##1 ack_oe_n;
    endproperty
    property p_rst_float;
        !dev_reset_n && !$past(dev_reset_n) |->
            dev_low_oe_n && dev_high_oe_n && ack_oe_n;
    endproperty
    property p_rst_len;
        $fell(dev_reset_n) |-> (!dev_reset_n) [*5];
    endproperty
    property p_plain_ale;
        !bus_style_select |-> !addr_latch_strobe;
    endproperty
    property p_wr_float;
        !port_sel_n && !dir_write_sel |-> dev_low_oe_n && dev_high_oe_n;
    endproperty
    property p_plain_rd;
        !bus_style_select && !port_sel_n && !data_strobe && dir_write_sel
            && !transfer_ack_n |-> !dev_low_oe_n && !dev_high_oe_n;
    endproperty
    property p_plain_ack;
        s_plain_go |-> ##[1:3] !transfer_ack_n;
    endproperty
    property p_mux_ack;
        s_mux_go |-> ##[1:6] !transfer_ack_n;
    endproperty

    a_ack_sel: assert property (p_ack_sel)
        else $error("ack without port select");
    a_ack_end: assert property (p_ack_end)
        else $error("ack not driven high before release");
    a_rst_float: assert property (p_rst_float)
        else $error("outputs driven in device reset");
    a_rst_len: assert property (p_rst_len)
        else $error("device reset pulse too short");
    a_plain_ale: assert property (p_plain_ale)
        else $error("latch strobe not grounded in plain mode");
    a_wr_float: assert property (p_wr_float)
        else $error("device drives data during write");
    a_plain_rd: assert property (p_plain_rd)
        else $error("read data not driven");
    a_plain_ack: assert property (p_plain_ack)
        else $error("no ack after plain strobe");
    a_mux_ack: assert property (p_mux_ack)
        else $error("no ack after muxed address latch");
endmodule

// >>> tb/test_cpu_port_strobe_decode.sv
`timescale 1ns/10ps
`include "cpst_regs.svh"

module test_cpu_port_strobe_decode
    import cpst_pkg::*;
;
    logic        ref_clk, reset, muxed_mode, rw_strobes, req, req_write;
    logic        rst_req, busy, done, write_seen, write_seen2;
    logic [7:0]  req_addr, core_rd_addr, core_rd_addr2, a;
    logic [15:0] req_wdata, rdata, core_rd_data, core_rd_data2, d;
    logic [15:0] serial_data, ser_out, ser_oe;
    cpst_style_e active_style;
    int          bad_count, total_checks, wr_cnt, wr2_cnt, ack2_cnt, n;
    logic [7:0]  addr_t[3]  = '{8'h00, 8'hFF, 8'h5A};
    logic [15:0] data_t[3]  = '{16'h1234, 16'hABCD, 16'h8001};
    cpst_style_e style_t[3] = '{CPST_STYLE_DS_PLAIN, CPST_STYLE_DS_MUXED,
                                CPST_STYLE_RW_STROBE};

    cpst_if link ();
    cpst_if link2 ();

    cpst_host cpst_host_inst (.ref_clk(ref_clk), .reset(reset),
        .bus(link.host), .muxed_mode(muxed_mode), .rw_strobes(rw_strobes),
        .req(req), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rst_req(rst_req), .busy(busy),
        .done(done), .rdata(rdata));
    cpst_dev cpst_dev_inst (.ref_clk(ref_clk), .reset(reset),
        .bus(link.dev), .serial_data(serial_data),
        .serial_out_streams(ser_out), .serial_out_oe_n(ser_oe),
        .core_rd_addr(core_rd_addr), .core_rd_data(core_rd_data),
        .active_style(active_style), .write_seen(write_seen));
    // second device faces the bench, which breaks the host's rules
    cpst_dev cpst_dev_inst2 (.ref_clk(ref_clk), .reset(reset),
        .bus(link2.dev), .serial_data(serial_data),
        .serial_out_streams(), .serial_out_oe_n(),
        .core_rd_addr(core_rd_addr2), .core_rd_data(core_rd_data2),
        .active_style(), .write_seen(write_seen2));
    cpst_port_props cpst_port_props_inst (.ref_clk(ref_clk),
        .reset(reset), .port_sel_n(link.port_sel_n),
        .data_strobe(link.data_strobe),
        .dir_write_sel(link.dir_write_sel),
        .addr_latch_strobe(link.addr_latch_strobe),
        .bus_style_select(link.bus_style_select),
        .dev_reset_n(link.dev_reset_n), .dev_low_oe_n(link.dev_low_oe_n),
        .dev_high_oe_n(link.dev_high_oe_n), .ack_out(link.ack_out),
        .ack_oe_n(link.ack_oe_n), .transfer_ack_n(link.transfer_ack_n));

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        if (write_seen === 1'b1) wr_cnt++;
        if (write_seen2 === 1'b1) wr2_cnt++;
        if (link2.transfer_ack_n === 1'b0) ack2_cnt++;
    end

    // ----------------------------------------------------------------
    // bench tasks
    // ----------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic access(input logic wr, input logic [7:0] ad,
                          input logic [15:0] wd);
        n = 0;
        while (busy !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
        req = 1'b1;
        req_write = wr;
        req_addr = ad;
        req_wdata = wd;
        tick(1);
        req = 1'b0;
        while (done !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
        if (n >= 80) check(16'h0000, 16'h0001);
        tick(1);
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 0;
        reset = 1;
        muxed_mode = 0;
        rw_strobes = 0;
        req = 0;
        req_write = 0;
        req_addr = 0;
        req_wdata = 0;
        rst_req = 0;
        serial_data = 16'hA5C3;
        core_rd_addr = 0;
        core_rd_addr2 = 0;
        bad_count = 0;
        total_checks = 0;
        wr_cnt = 0;
        wr2_cnt = 0;
        ack2_cnt = 0;
        link2.port_sel_n = 1;
        link2.data_strobe = 1;
        link2.dir_write_sel = 1;
        link2.addr_latch_strobe = 0;
        link2.bus_style_select = 0;
        link2.addr_lines = 8'h3C;
        link2.dev_reset_n = 1;
        link2.host_low_out = 8'hEF;
        link2.host_low_oe_n = 1;
        link2.host_high_out = 8'hBE;
        link2.host_high_oe_n = 1;
        tick(8);
        reset = 0;
        tick(2);
        check(ser_oe, 16'hFFFF);
        for (int s = 0; s < 3; s++) begin
            muxed_mode = (s != 0);
            rw_strobes = (s == 2);
            a = addr_t[s];
            d = data_t[s];
            access(1'b1, a, d);
            access(1'b1, ~a, ~d);
            check({13'h0, active_style}, {13'h0, style_t[s]});
            access(1'b0, a, 16'h0000);
            check(rdata, d);
            access(1'b0, ~a, 16'h0000);
            check(rdata, ~d);
            core_rd_addr = a;
            tick(2);
            check(core_rd_data, d);
        end
        check(16'(wr_cnt), 16'h0006);
        check(ser_out, 16'hA5C3);
        check(ser_oe, 16'h0000);
        // device reset mid-run; memory survives by design choice
        rst_req = 1'b1;
        tick(1);
        rst_req = 1'b0;
        tick(2);
        check(ser_oe, 16'hFFFF);
        check({15'h0, link.transfer_ack_n}, 16'h0001);
        access(1'b0, ~a, 16'h0000);
        check(rdata, ~d);
        // strobes with port select high must be ignored
        link2.dir_write_sel = 0;
        link2.host_low_oe_n = 0;
        link2.host_high_oe_n = 0;
        link2.data_strobe = 0;
        tick(4);
        check(16'(ack2_cnt + wr2_cnt), 16'h0000);
        // latch strobe raised in plain mode must not disturb a write
        link2.addr_latch_strobe = 1;
        link2.port_sel_n = 0;
        n = 0;
        while (link2.transfer_ack_n !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        tick(1);
        link2.data_strobe = 1;
        link2.port_sel_n = 1;
        link2.addr_latch_strobe = 0;
        link2.host_low_oe_n = 1;
        link2.host_high_oe_n = 1;
        link2.dir_write_sel = 1;
        core_rd_addr2 = 8'h3C;
        tick(4);
        check(core_rd_data2, 16'hBEEF);
        check({15'h0, link2.transfer_ack_n}, 16'h0001);
        stop_test();
    end

    initial begin
        #100us;
        bad_count++;
        stop_test();
    end
endmodule
